// ===== dv/ssd_gw_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssd_gw_model (
  input  wire logic          sys_clk_in,
  output ssd_pkg::ssd_byte_t req_byte_out,
  output logic               req_stb_out,
  output logic               comm_fail_out
);
  import ssd_pkg::*;
  initial begin
    req_byte_out = 8'h00;
    req_stb_out = 1'b0;
    comm_fail_out = 1'b0;
  end
  // One byte per strobe; stale byte inverted so it is never reused
  task automatic send(input ssd_byte_t b);
    @(posedge sys_clk_in);
    req_byte_out <= b;
    req_stb_out <= 1'b1;
    @(posedge sys_clk_in);
    req_stb_out <= 1'b0;
    req_byte_out <= ~b;
  endtask
  task automatic link(input logic f);
    @(posedge sys_clk_in);
    comm_fail_out <= f;
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import ssd_pkg::*;
  logic        clk, rstn, det, lim, bad, ierr, sa, sb, wcyc, wstb, wwe;
  logic [3:0]  flt, wsel;
  logic [7:0]  wadr;
  logic [31:0] wdat, wq, q, r;
  logic        ack, soa, sob, dok, irq, stb, cf;
  ssd_byte_t   resp, diag, rb;
  int          bad_count, total_checks, cycles, k;
  ssd_gw_model ssd_gw_model_inst (.sys_clk_in(clk), .req_byte_out(rb),
    .req_stb_out(stb), .comm_fail_out(cf));
  // Short time base: timeout after 20 cycles of warning
  ssd_diag_status #(.TICK_CYCLES(4), .WARN_TICKS(5)) ssd_diag_status_inst (
    .sys_clk_in(clk), .rstn_in(rstn), .flt_out_a_in(flt[0]),
    .flt_out_b_in(flt[1]), .flt_cross_in(flt[2]), .flt_temp_in(flt[3]),
    .act_detect_in(det), .act_limit_in(lim), .act_bad_in(bad),
    .int_err_in(ierr), .safety_in_a_in(sa), .safety_in_b_in(sb),
    .req_byte_in(rb), .req_stb_in(stb), .comm_fail_in(cf),
    .wb_cyc_in(wcyc), .wb_stb_in(wstb), .wb_we_in(wwe), .wb_adr_in(wadr),
    .wb_sel_in(wsel), .wb_dat_in(wdat), .wb_ack_out(ack), .wb_dat_out(wq),
    .safety_out_a_out(soa), .safety_out_b_out(sob), .diag_ok_out(dok),
    .resp_byte_out(resp), .diag_byte_out(diag), .irq_out(irq));
  // Status byte expected from actuator and input levels, no fault pending
  function automatic ssd_byte_t exp_resp(input logic d, input logic l,
                                         input logic a, input logic b);
    logic on;
    on = d & a & b;
    exp_resp = {2'b00, on & l, a & b, 2'b00, d, on};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // No local limit: only the cycle ceiling ends a hung access
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    wcyc <= 1'b1;
    wstb <= 1'b1;
    wwe <= w;
    wadr <= a;
    wdat <= d;
    wsel <= s;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = wq;
    wcyc <= 1'b0;
    wstb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic clr_err();
    ssd_gw_model_inst.send(8'h80);
    ssd_gw_model_inst.send(8'h00);
    wt(6);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Ceiling well above the roughly 320 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h26c4));
    {rstn, det, lim, bad, ierr, wcyc, wstb, wwe, flt} = '0;
    {sa, sb, wsel, wadr, wdat} = {2'b11, 44'h0};
    wt(20);
    rstn <= 1'b1;
    wt(6);
    `CHK("idle resp", 8'h10, resp)
    det <= 1'b1;
    wt(6);
    `CHK("on resp", 8'h13, resp)
    `CHK("on outs", 2'b11, {soa, sob})
    lim <= 1'b1;
    wt(6);
    `CHK("limit resp", 8'h33, resp)
    lim <= 1'b0;
    wb(1, 8'h10, 32'h1, 4'hf);
    wb(1, 8'h0c, 32'hf, 4'hf);
    $display("test basic done");
    // Sum of holds exceeds the timeout, so a counter that never restarts fails
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h1 << i;
      wt(6 + $urandom_range(6));
      `CHK("warn resp", 8'h53, resp)
      `CHK("warn outs", 3'b110, {soa, sob, dok})
      `CHK("warn diag", 4'h1 << i, diag[3:0])
      `CHK("warn irq", 1'b1, irq)
      wb(0, 8'h0c, 0, 4'hf);
      `CHK("stat", 1'b1, q[0])
      flt <= 4'h0;
      wt(6);
      `CHK("clear resp", 8'h13, resp)
      `CHK("clear ok", 1'b1, dok)
      wb(1, 8'h0c, 32'h1, 4'hf);
      wt(2);
      `CHK("irq clr", 1'b0, irq)
    end
    $display("test warn done");
    k = $urandom_range(3);
    flt <= 4'h1 << k;
    wt(30);
    `CHK("tmo err", 1'b1, resp[7])
    `CHK("tmo outs", 2'b00, {soa, sob})
    `CHK("tmo diag", 4'h1 << k, diag[3:0])
    flt <= 4'h0;
    wt(6);
    `CHK("err held", 1'b1, resp[7])
    clr_err();
    `CHK("req reset", 8'h13, resp)
    $display("test timeout done");
    ssd_gw_model_inst.link(1'b1);
    ierr <= 1'b1;
    wt(6);
    `CHK("frozen", 2'b11, {soa, sob})
    `CHK("comm err", 3'b111, {resp[7], diag[6:5]})
    ssd_gw_model_inst.link(1'b0);
    ierr <= 1'b0;
    wt(6);
    `CHK("unfrozen", 2'b00, {soa, sob})
    clr_err();
    bad <= 1'b1;
    wt(6);
    `CHK("bad act", 3'b100, {diag[4], soa, sob})
    bad <= 1'b0;
    det <= 1'b0;
    wt(6);
    `CHK("guard rst", 1'b0, resp[7])
    det <= 1'b1;
    wt(6);
    `CHK("reclose", 8'h13, resp)
    $display("test errors done");
    wb(0, 8'h00, 0, 4'hf);
    `CHK("rd resp", 32'h13, q)
    ssd_gw_model_inst.send(8'h5a);
    wb(0, 8'h08, 0, 4'hf);
    `CHK("rd req", 32'h5a, q)
    // Write without byte lane 0 must leave the mask alone
    wb(1, 8'h10, 32'h9, 4'h0);
    wb(0, 8'h10, 0, 4'hf);
    `CHK("rd mask", 32'h1, q)
    wb(0, 8'h20, 0, 4'hf);
    `CHK("unmapped", 32'h0, q)
    wb(1, 8'h0c, 32'hf, 4'hf);
    wb(1, 8'h10, 32'h8, 4'h1);
    `CHK("irq quiet", 1'b0, irq)
    ssd_gw_model_inst.send(8'h11);
    wt(2);
    `CHK("irq req", 1'b1, irq)
    wb(0, 8'h0c, 0, 4'hf);
    `CHK("stat req", 1'b1, q[3])
    wb(1, 8'h0c, 32'h8, 4'h1);
    wt(2);
    `CHK("irq req clr", 1'b0, irq)
    $display("test regs done");
    // Corner levels first, then random actuator and input levels
    for (int j = 0; j < 10; j++) begin
      r = $urandom;
      if (j == 0)
        r[3:0] = 4'ha;
      else if (j == 1)
        r[3:0] = 4'h7;
      {det, lim, sa, sb} <= r[3:0];
      wt(6);
      `CHK("rnd resp", exp_resp(r[3], r[2], r[1], r[0]), resp)
      `CHK("rnd outs", {2{r[3] & r[1] & r[0]}}, {soa, sob})
      `CHK("rnd ok", r[3] & r[1] & r[0], dok)
    end
    $display("test random done");
    end_sim();
  end
endmodule
`default_nettype wire

// ===== hdl/ssd_diag_status.sv
// Contract
// - A warning-class fault drops the diagnostic indication but leaves both safety outputs on.
// - A warning clears by itself as soon as its cause is gone.
// - A warning that stays active for 30 minutes also switches both safety outputs off.
// - The diagnostic byte flags output A, output B, cross-wire and overtemperature in bits 0 to 3.
// - The device presents its response byte and diagnostic byte toward the controller.
// - Response bit 0 shows enabled safety outputs and bit 1 a detected actuator.
// - Response bit 5 shows an actuator in the limit zone while the outputs are on.
// - Diagnostics also flag a bad actuator, an internal error and a communication failure.
// - Response bit 6 shows an active warning and bit 7 an error that switched outputs off.
// - Response bit 4 shows both safety inputs energised.
// - An error resets once its cause is gone and request bit 7 falls or the guard opens.
// - While communication has failed the safety outputs hold their state.
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_regs.svh"

module ssd_diag_status #(
  parameter int unsigned TICK_CYCLES = `SSD_TICK_NS / `SSD_CLK_NS,
  parameter int unsigned WARN_TICKS  = `SSD_WARN_MIN * `SSD_TICKS_PER_MIN
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             flt_out_a_in,
  input  wire logic             flt_out_b_in,
  input  wire logic             flt_cross_in,
  input  wire logic             flt_temp_in,
  input  wire logic             act_detect_in,
  input  wire logic             act_limit_in,
  input  wire logic             act_bad_in,
  input  wire logic             int_err_in,
  input  wire logic             safety_in_a_in,
  input  wire logic             safety_in_b_in,
  input  wire ssd_pkg::ssd_byte_t req_byte_in,
  input  wire logic             req_stb_in,
  input  wire logic             comm_fail_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [7:0]       wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic                  wb_ack_out,
  output logic [31:0]           wb_dat_out,
  output logic                  safety_out_a_out,
  output logic                  safety_out_b_out,
  output logic                  diag_ok_out,
  output ssd_pkg::ssd_byte_t    resp_byte_out,
  output ssd_pkg::ssd_byte_t    diag_byte_out,
  output logic                  irq_out
);
  import ssd_pkg::*;

  localparam int PW = 10;

  // Pin synchronisers; only pin_s is read by logic
  logic [PW-1:0] pin_m;
  logic [PW-1:0] pin_s;
  wire  [PW-1:0] pin_raw = {safety_in_b_in, safety_in_a_in, int_err_in,
                            act_bad_in, act_limit_in, act_detect_in,
                            flt_temp_in, flt_cross_in, flt_out_b_in,
                            flt_out_a_in};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_m <= '0;
      pin_s <= '0;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
    end
  end

  wire [3:0] warn_cause = pin_s[3:0];
  wire       act_det    = pin_s[4];
  wire       act_lim    = pin_s[5];
  wire       act_bad    = pin_s[6];
  wire       int_err    = pin_s[7];
  wire       ins_ok     = pin_s[8] & pin_s[9];
  wire       warn_now   = |warn_cause;

  ssd_warn_e   state_r;
  ssd_warn_e   state_nxt;
  logic [31:0] pre_r;
  logic [31:0] ms_r;
  logic        act_det_r;
  logic        err_r;
  logic [5:0]  err_lat_r;
  logic        safety_r;
  logic        diag_ok_r;
  ssd_byte_t   resp_r;
  ssd_byte_t   diag_r;
  ssd_byte_t   req_r;

  // Time base runs only while a warning is pending
  wire tick    = (state_r == SSD_WARN) && (pre_r == TICK_CYCLES - 1);
  wire expire  = tick && (ms_r == WARN_TICKS - 1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSD_IDLE:    if (warn_now) state_nxt = SSD_WARN;
      SSD_WARN:    if (!warn_now) state_nxt = SSD_IDLE;
                   else if (expire) state_nxt = SSD_EXPIRED;
      SSD_EXPIRED: if (!warn_now) state_nxt = SSD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= SSD_IDLE;
      pre_r   <= '0;
      ms_r    <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != SSD_WARN) begin
        pre_r <= '0;
        ms_r  <= '0;
      end else if (tick) begin
        pre_r <= '0;
        ms_r  <= ms_r + 32'h1;
      end else begin
        pre_r <= pre_r + 32'h1;
      end
    end
  end

  wire warn_act  = state_r != SSD_IDLE;
  wire req_fall  = req_stb_in && req_r[`SSD_REQ_RESET]
                   && !req_byte_in[`SSD_REQ_RESET];
  wire guard_opn = act_det_r && !act_det;
  wire err_set   = act_bad || int_err || expire;
  wire err_cause = act_bad || int_err || (state_r == SSD_EXPIRED);
  wire err_clr   = err_r && !err_cause && (req_fall || guard_opn);
  wire err_nxt   = err_set || (err_r && !err_clr);
  wire [5:0] err_lat_nxt = err_clr ? 6'h00 :
                           err_lat_r | (err_set ? {int_err, act_bad,
                                        warn_cause} : 6'h00);

  // Outputs hold while the chain is down; trades prompt shutdown for
  // immunity to gateway loss
  wire safety_ok  = act_det && ins_ok && !err_nxt;
  wire safety_nxt = comm_fail_in ? safety_r : safety_ok;
  wire diag_ok_nxt = safety_nxt && !warn_act && !err_nxt;

  wire [7:0] resp_nxt = {err_nxt, warn_act,
                         act_lim && act_det && safety_nxt,
                         ins_ok,
                         2'b00, act_det, safety_nxt};
  wire [3:0] dg_cause = err_nxt ? err_lat_nxt[3:0] : warn_cause;
  wire [7:0] diag_nxt = {1'b0, comm_fail_in, err_lat_nxt[5:4],
                         dg_cause};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_det_r <= 1'b0;
      err_r     <= 1'b0;
      err_lat_r <= '0;
      safety_r  <= 1'b0;
      diag_ok_r <= 1'b0;
      resp_r    <= `SSD_RST_BYTE;
      diag_r    <= `SSD_RST_BYTE;
      req_r     <= `SSD_RST_BYTE;
    end else begin
      act_det_r <= act_det;
      err_r     <= err_nxt;
      err_lat_r <= err_lat_nxt;
      safety_r  <= safety_nxt;
      diag_ok_r <= diag_ok_nxt;
      resp_r    <= resp_nxt;
      diag_r    <= diag_nxt;
      if (req_stb_in)
        req_r <= req_byte_in;
    end
  end

  // Interrupt events
  logic     warn_act_r;
  logic     comm_r;
  ssd_irq_t stat_r;
  ssd_irq_t mask_r;
  logic     irq_r;
  logic     ack_r;
  logic [31:0] dat_r;

  wire [3:0] ev = {req_stb_in, comm_fail_in && !comm_r,
                   err_nxt && !err_r, warn_act && !warn_act_r};
  wire wb_req   = wb_cyc_in && wb_stb_in && !ack_r;
  wire wr_stat  = wb_req && wb_we_in && wb_sel_in[0]
                  && (wb_adr_in == `SSD_ADR_IRQ_STAT);
  wire wr_mask  = wb_req && wb_we_in && wb_sel_in[0]
                  && (wb_adr_in == `SSD_ADR_IRQ_MASK);
  // Set beats clear in the same cycle
  wire [3:0] stat_nxt = (stat_r & ~(wr_stat ? wb_dat_in[3:0] : 4'h0)) | ev;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr_in)
      `SSD_ADR_RESP:     rd_mux = {24'h0, resp_r};
      `SSD_ADR_DIAG:     rd_mux = {24'h0, diag_r};
      `SSD_ADR_REQ:      rd_mux = {24'h0, req_r};
      `SSD_ADR_IRQ_STAT: rd_mux = {28'h0, stat_r};
      `SSD_ADR_IRQ_MASK: rd_mux = {28'h0, mask_r};
      default:           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      warn_act_r <= 1'b0;
      comm_r     <= 1'b0;
      stat_r     <= `SSD_RST_IRQ;
      mask_r     <= `SSD_RST_IRQ;
      irq_r      <= 1'b0;
      ack_r      <= 1'b0;
      dat_r      <= '0;
    end else begin
      warn_act_r <= warn_act;
      comm_r     <= comm_fail_in;
      stat_r     <= stat_nxt;
      if (wr_mask)
        mask_r <= wb_dat_in[3:0];
      irq_r <= |(stat_r & mask_r);
      ack_r <= wb_req;
      if (wb_req)
        dat_r <= wb_we_in ? 32'h0 : rd_mux;
    end
  end

  assign wb_ack_out       = ack_r;
  assign wb_dat_out       = dat_r;
  assign safety_out_a_out = safety_r;
  assign safety_out_b_out = safety_r;
  assign diag_ok_out      = diag_ok_r;
  assign resp_byte_out    = resp_r;
  assign diag_byte_out    = diag_r;
  assign irq_out          = irq_r;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_expire;
    (state_r == SSD_WARN) && expire && warn_now;
  endsequence
  sequence s_err_off;
    ##1 (state_r == SSD_EXPIRED) && err_r;
  endsequence

  chk_warn_diag_low: assert property (
    resp_r[`SSD_RSP_WARN] |-> !diag_ok_r)
    else $error("diag indication high during warning");
  chk_warn_keeps_on: assert property (
    warn_now && !err_nxt && act_det && ins_ok && !comm_fail_in
    |=> safety_r)
    else $error("warning switched outputs off early");
  chk_warn_clears: assert property (
    warn_act && !warn_now
    |=> state_r == SSD_IDLE ##1 !resp_r[`SSD_RSP_WARN])
    else $error("warning did not clear");
  chk_timeout_err: assert property (s_expire |-> s_err_off)
    else $error("timeout did not raise error");
  chk_err_off: assert property (
    err_r && !err_clr && !comm_fail_in
    |=> !safety_out_a_out && !safety_out_b_out)
    else $error("outputs on during error");
  chk_resp_status: assert property (
    resp_r[`SSD_RSP_EN] == safety_r && $past(act_det) == resp_r[1])
    else $error("status bits wrong");
  chk_comm_hold: assert property (
    comm_fail_in |=> $stable(safety_r))
    else $error("outputs moved during comm failure");
  chk_cnt_restart: assert property (
    state_r == SSD_IDLE |-> ms_r == 32'h0 && pre_r == 32'h0)
    else $error("timeout counter not restarted");
  chk_err_reset: assert property (
    err_clr && !err_set |=> !err_r && !resp_r[`SSD_RSP_ERR])
    else $error("error not reset");
  chk_irq_level: assert property (
    |(stat_r & mask_r) |=> irq_out)
    else $error("interrupt not raised");
endmodule

`default_nettype wire

// ===== hdl/ssd_pkg.sv
package ssd_pkg;
  typedef enum logic [1:0] {SSD_IDLE, SSD_WARN, SSD_EXPIRED} ssd_warn_e;
  typedef logic [7:0] ssd_byte_t;
  typedef logic [3:0] ssd_irq_t;
endpackage

// ===== hdl/ssd_regs.svh
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// Time base
`define SSD_CLK_NS        100
`define SSD_TICK_NS       1000000
`define SSD_TICKS_PER_MIN 60000
`define SSD_WARN_MIN      30

// Wishbone register byte offsets
`define SSD_ADR_RESP      8'h00
`define SSD_ADR_DIAG      8'h04
`define SSD_ADR_REQ       8'h08
`define SSD_ADR_IRQ_STAT  8'h0c
`define SSD_ADR_IRQ_MASK  8'h10

// Response byte fields
`define SSD_RSP_EN        0
`define SSD_RSP_ACT       1
`define SSD_RSP_INS       4
`define SSD_RSP_LIMIT     5
`define SSD_RSP_WARN      6
`define SSD_RSP_ERR       7

// Diagnostic byte fields (bits 3:0 are the fault causes)
`define SSD_DG_BAD_ACT    4
`define SSD_DG_INT_ERR    5
`define SSD_DG_COMM       6

// Request byte: error reset on falling edge
`define SSD_REQ_RESET     7

// Interrupt status bits
`define SSD_IRQ_WARN      0
`define SSD_IRQ_ERR       1
`define SSD_IRQ_COMM      2
`define SSD_IRQ_REQ       3

`define SSD_RST_BYTE      8'h00
`define SSD_RST_IRQ       4'h0

`endif
